// ===== design/spi_port_setup.sv
// Register file, enable protection and clock output of the serial port.
// Assumes an APB master on clk and external pads driven via enables.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Protected configuration writes only accepted while the enable state is off.
// - Protected: control A except enable/reset, control B except RX, baud, addr.
// - Writes while enabled or enabling are dropped, contents unchanged.
// - The last write during a disable is held and done after it finishes.
// - Mode field 0x3 selects master, 0x2 selects slave.
// - Master drives slave-select in hardware only when select enable set.
// - Writing enable one starts the port from off, zero stops it from on.
// - Soft reset clears all registers except debug control, port disabled.
// - Master mode generates the serial clock internally and drives it.
// - Baud generator synchronous; 8-bit baud sets clock and shift rate.
module spi_port_setup (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOutEnN,
  output logic selectOut,
  output logic selectOutEnN,
  output logic shiftTick,
  output logic receiverEnable
);

  // ==========================================================
  // State of the enable handshake
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_ENABLING = 4'h2,
    ST_ON = 4'h4,
    ST_DISABLING = 4'h8
  } en_state_t;

  en_state_t state_reg;
  en_state_t state_next;
  logic [1:0] syncCnt_reg;
  logic [31:0] control_reg_a_reg;
  logic [31:0] control_reg_b_reg;
  logic [7:0] baud_reg;
  logic [31:0] addr_reg;
  logic dbg_reg;
  spi_port_pkg::held_write_t held_reg;
  spi_port_pkg::port_cfg_t cfg;
  logic access;
  logic wrAccess;
  logic softReset;
  logic enableWrite;
  logic enableValue;
  logic protOpen;
  logic sckInt;
  logic sckInUnused;

  function automatic logic isProtected(input logic [7:0] a);
    isProtected = (a == spi_port_pkg::CONTROL_REG_A_OFS) ||
      (a == spi_port_pkg::CONTROL_REG_B_OFS) || (a == spi_port_pkg::BAUD_OFS) ||
      (a == spi_port_pkg::ADDR_OFS);
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = isProtected(a) || (a == spi_port_pkg::DBG_OFS) ||
      (a == spi_port_pkg::STATUS_OFS);
  endfunction

  // ==========================================================
  // APB slave: zero wait states, error on unmapped address
  assign access = psel && penable;
  assign wrAccess = access && pwrite;
  assign pready = 1'b1;
  assign pslverr = access && !isMapped(paddr);

  assign softReset = wrAccess && (paddr == spi_port_pkg::CONTROL_REG_A_OFS) &&
    pwdata[spi_port_pkg::SOFT_RESET_BIT_BIT];
  assign enableWrite = wrAccess && (paddr == spi_port_pkg::CONTROL_REG_A_OFS) &&
    !pwdata[spi_port_pkg::SOFT_RESET_BIT_BIT];
  assign enableValue = pwdata[spi_port_pkg::ENABLE_BIT];
  // Protected fields may be changed along with setting enable from off
  assign protOpen = (state_reg == ST_OFF);

  // ==========================================================
  // Enable state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:
      begin
        if (enableWrite && enableValue)
        begin
          state_next = ST_ENABLING;
        end
      end
      ST_ENABLING:
      begin
        if (syncCnt_reg == spi_port_pkg::SYNC_CYCLES)
        begin
          state_next = ST_ON;
        end
      end
      ST_ON:
      begin
        if (enableWrite && !enableValue)
        begin
          state_next = ST_DISABLING;
        end
      end
      ST_DISABLING:
      begin
        if (syncCnt_reg == spi_port_pkg::SYNC_CYCLES)
        begin
          state_next = ST_OFF;
        end
      end
      default:
      begin
        state_next = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset || softReset)
    begin
      state_reg <= ST_OFF;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || softReset || state_next != state_reg)
    begin
      syncCnt_reg <= 2'h0;
    end
    else if (state_reg == ST_ENABLING || state_reg == ST_DISABLING)
    begin
      syncCnt_reg <= syncCnt_reg + 2'h1;
    end
  end

  // ==========================================================
  // Held write during disable; only the latest one is kept
  // A control A write here sets its enable bit at once; the
  // protected fields wait, so none is lost to the disable
  always_ff @(posedge clk)
  begin
    if (reset || softReset)
    begin
      held_reg <= '0;
    end
    else if (wrAccess && isProtected(paddr) &&
      state_reg == ST_DISABLING)
    begin
      held_reg <= '{valid: 1'b1, addr: paddr, data: pwdata};
    end
    else if (state_reg == ST_OFF)
    begin
      held_reg.valid <= 1'b0;
    end
  end

  // ==========================================================
  // Control A: enable bit always writable, rest protected
  always_ff @(posedge clk)
  begin
    if (reset || softReset)
    begin
      control_reg_a_reg <= spi_port_pkg::CONTROL_REG_A_RST;
    end
    else
    begin
      if (enableWrite)
      begin
        control_reg_a_reg[spi_port_pkg::ENABLE_BIT] <= enableValue;
      end
      if (enableWrite && protOpen)
      begin
        control_reg_a_reg[31:2] <= pwdata[31:2];
      end
      else if (held_reg.valid && state_reg == ST_OFF &&
        held_reg.addr == spi_port_pkg::CONTROL_REG_A_OFS)
      begin
        control_reg_a_reg[31:2] <= held_reg.data[31:2];
      end
    end
  end

  // Control B: receiver enable always writable, rest protected
  always_ff @(posedge clk)
  begin
    if (reset || softReset)
    begin
      control_reg_b_reg <= spi_port_pkg::CONTROL_REG_B_RST;
    end
    else if (wrAccess && paddr == spi_port_pkg::CONTROL_REG_B_OFS)
    begin
      control_reg_b_reg[spi_port_pkg::RECEIVER_ENABLE_BIT_BIT] <= pwdata[spi_port_pkg::RECEIVER_ENABLE_BIT_BIT];
      if (protOpen)
      begin
        control_reg_b_reg <= pwdata;
      end
    end
    else if (held_reg.valid && state_reg == ST_OFF &&
      held_reg.addr == spi_port_pkg::CONTROL_REG_B_OFS)
    begin
      control_reg_b_reg <= held_reg.data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || softReset)
    begin
      baud_reg <= spi_port_pkg::BAUD_RST;
    end
    else if (wrAccess && paddr == spi_port_pkg::BAUD_OFS && protOpen)
    begin
      baud_reg <= pwdata[7:0];
    end
    else if (held_reg.valid && state_reg == ST_OFF &&
      held_reg.addr == spi_port_pkg::BAUD_OFS)
    begin
      baud_reg <= held_reg.data[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || softReset)
    begin
      addr_reg <= spi_port_pkg::ADDR_RST;
    end
    else if (wrAccess && paddr == spi_port_pkg::ADDR_OFS && protOpen)
    begin
      addr_reg <= pwdata;
    end
    else if (held_reg.valid && state_reg == ST_OFF &&
      held_reg.addr == spi_port_pkg::ADDR_OFS)
    begin
      addr_reg <= held_reg.data;
    end
  end

  // Debug control survives a soft reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dbg_reg <= spi_port_pkg::DBG_RST;
    end
    else if (wrAccess && paddr == spi_port_pkg::DBG_OFS)
    begin
      dbg_reg <= pwdata[0];
    end
  end

  // ==========================================================
  // Read data from flip-flops, captured in the setup cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        spi_port_pkg::CONTROL_REG_A_OFS: prdata <= control_reg_a_reg;
        spi_port_pkg::CONTROL_REG_B_OFS: prdata <= control_reg_b_reg;
        spi_port_pkg::BAUD_OFS: prdata <= {24'h000000, baud_reg};
        spi_port_pkg::ADDR_OFS: prdata <= addr_reg;
        spi_port_pkg::DBG_OFS: prdata <= {31'h0, dbg_reg};
        spi_port_pkg::STATUS_OFS: prdata <= {27'h0, held_reg.valid, state_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Configuration to the clock generator and pads
  always_comb
  begin
    cfg.enabled = (state_reg == ST_ON);
    cfg.master = (control_reg_a_reg[spi_port_pkg::MODE_LSB +: spi_port_pkg::MODE_W]
      == spi_port_pkg::MODE_MASTER);
    cfg.slave = (control_reg_a_reg[spi_port_pkg::MODE_LSB +: spi_port_pkg::MODE_W]
      == spi_port_pkg::MODE_SLAVE);
    cfg.clock_polarity_sel = control_reg_a_reg[spi_port_pkg::CLOCK_POLARITY_SEL_BIT];
    cfg.hwSelect = control_reg_b_reg[spi_port_pkg::HW_SELECT_ENABLE_BIT];
    cfg.baud = baud_reg;
  end

  spi_baud_gen baudGen (
    .clk(clk),
    .reset(reset),
    .cfg(cfg),
    .sck(sckInt),
    .shiftTick(shiftTick)
  );

  // Slave clock input is consumed by the shifter, outside this block
  assign sckInUnused = sckIn;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sckOut <= 1'b0;
      sckOutEnN <= 1'b1;
      selectOut <= 1'b1;
      selectOutEnN <= 1'b1;
      receiverEnable <= 1'b0;
    end
    else
    begin
      sckOut <= sckInt;
      sckOutEnN <= !(cfg.enabled && cfg.master);
      selectOut <= !(cfg.enabled && cfg.master);
      selectOutEnN <= !(cfg.enabled && cfg.master && cfg.hwSelect);
      receiverEnable <= cfg.enabled && control_reg_b_reg[spi_port_pkg::RECEIVER_ENABLE_BIT_BIT];
    end
  end

endmodule
`default_nettype wire

// ===== design/spi_port_pkg.sv
// Package for the serial peripheral port setup block.
// Assumes a 32-bit APB register bus and a single core clock.
package spi_port_pkg;

  // ==========================================================
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] CONTROL_REG_A_OFS = 8'h00;
  localparam logic [7:0] CONTROL_REG_B_OFS = 8'h04;
  localparam logic [7:0] BAUD_OFS = 8'h0c;
  localparam logic [7:0] ADDR_OFS = 8'h24;
  localparam logic [7:0] DBG_OFS = 8'h30;
  localparam logic [7:0] STATUS_OFS = 8'h1c;

  // ==========================================================
  // Control A field positions
  localparam int SOFT_RESET_BIT_BIT = 0;
  localparam int ENABLE_BIT = 1;
  localparam int MODE_LSB = 2;
  localparam int MODE_W = 3;
  localparam int TRANSMIT_PAD_MAP_LSB = 16;
  localparam int RECEIVE_PAD_MAP_LSB = 20;
  localparam int FRAME_FORMAT_SEL_LSB = 24;
  localparam int CLOCK_PHASE_SEL_BIT = 28;
  localparam int CLOCK_POLARITY_SEL_BIT = 29;
  localparam int BIT_ORDER_SEL_BIT = 30;

  // Control B field positions
  localparam int CHARACTER_SIZE_SEL_LSB = 0;
  localparam int HW_SELECT_ENABLE_BIT = 13;
  localparam int RECEIVER_ENABLE_BIT_BIT = 17;

  // Operating mode codes
  localparam logic [2:0] MODE_SLAVE = 3'h2;
  localparam logic [2:0] MODE_MASTER = 3'h3;

  // Reset values
  localparam logic [31:0] CONTROL_REG_A_RST = 32'h0000_0000;
  localparam logic [31:0] CONTROL_REG_B_RST = 32'h0000_0000;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [0:0] DBG_RST = 1'h0;

  // Count at which an enable or disable settles in the core; the settle takes one cycle more
  localparam logic [1:0] SYNC_CYCLES = 2'h2;

  // ==========================================================
  // Configuration seen by the clock generator and pins
  typedef struct packed {
    logic enabled;
    logic master;
    logic slave;
    logic clock_polarity_sel;
    logic hwSelect;
    logic [7:0] baud;
  } port_cfg_t;

  // A write parked while the port is disabling
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [31:0] data;
  } held_write_t;

endpackage

// ===== design/spi_baud_gen.sv
// Synchronous baud-rate generator for master serial clock.
// Assumes cfg comes from flip-flops in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module spi_baud_gen (
  input wire logic clk,
  input wire logic reset,
  input wire spi_port_pkg::port_cfg_t cfg,
  output logic sck,
  output logic shiftTick
);

  logic [7:0] count_reg;
  logic sck_reg;
  logic run;

  assign run = cfg.enabled && cfg.master;

  // ==========================================================
  // Divider: half period is baud+1 core cycles
  always_ff @(posedge clk)
  begin
    if (reset || !run)
    begin
      count_reg <= 8'h00;
    end
    else if (count_reg == cfg.baud)
    begin
      count_reg <= 8'h00;
    end
    else
    begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // Idle level follows polarity so the first edge is a true edge
  always_ff @(posedge clk)
  begin
    if (reset || !run)
    begin
      sck_reg <= cfg.clock_polarity_sel;
    end
    else if (count_reg == cfg.baud)
    begin
      sck_reg <= !sck_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      shiftTick <= 1'b0;
    end
    else
    begin
      shiftTick <= run && (count_reg == cfg.baud) && (sck_reg != cfg.clock_polarity_sel);
    end
  end

  assign sck = sck_reg;

endmodule
`default_nettype wire

// ===== tb/spi_peer.sv
// Far-side serial peripheral: counts serial clock rising edges.
// Assumes the pad outputs of the port come straight in.
`timescale 1ns/1ps
`default_nettype none
module spi_peer (
  input wire logic clk,
  input wire logic sck,
  input wire logic sckEnN,
  output logic sckIn,
  output int edges
);
  logic sckLast;
  initial
  begin
    sckIn = 1'b0;
    edges = 0;
    sckLast = 1'b0;
  end
  // Line not driven by us here: toggle so no stale level looks valid
  always @(posedge clk)
  begin
    sckIn <= ~sckIn;
    sckLast <= sck;
    if (!sckEnN && sck && !sckLast)
      edges <= edges + 1;
  end
endmodule
`default_nettype wire

// ===== tb/spi_port_setup_sva.sv
// Port-level checks of the serial port setup block.
// Assumes binding to every spi_port_setup instance.
`timescale 1ns/1ps
`default_nettype none
module spi_port_setup_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sckOutEnN,
  input wire logic selectOut,
  input wire logic selectOutEnN,
  input wire logic shiftTick,
  input wire logic receiverEnable
);
  logic mapped;
  logic acc;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h0c, 8'h1c, 8'h24, 8'h30};
  assign acc = psel && penable;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ==========================================
  // Bus answers
  a_ready_zero_wait: assert property (acc |-> pready)
    else $error("pready low in access");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped address");
  a_mapped_no_err: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped address");
  a_unmapped_read_zero: assert property
    (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  // ==========================================
  // Pins
  a_tick_one_cycle: assert property (shiftTick |=> !shiftTick)
    else $error("shift tick longer than one cycle");
  a_tick_master_only: assert property
    (shiftTick |-> !sckOutEnN || !$past(sckOutEnN))
    else $error("shift tick without master clock");
  a_select_master_only: assert property
    (!selectOutEnN |-> !sckOutEnN && !selectOut)
    else $error("select driven outside master");
  a_reset_quiet: assert property (disable iff (1'b0)
    reset |=> sckOutEnN && selectOutEnN && selectOut && !receiverEnable)
    else $error("pins active after reset");
endmodule
bind spi_port_setup spi_port_setup_sva chk (.clk(clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sckOutEnN(sckOutEnN), .selectOut(selectOut),
  .selectOutEnN(selectOutEnN), .shiftTick(shiftTick),
  .receiverEnable(receiverEnable));
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the serial port setup block.
// Assumes zero-wait APB answers and a 3-cycle enable settle.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv, erv;
  logic pready, pslverr, sckIn, sckOut, sckOutEnN, selectOut;
  logic selectOutEnN, shiftTick, receiverEnable;
  logic [7:0] regs [5] = '{8'h00, 8'h04, 8'h0c, 8'h24, 8'h30};
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int edges;
  always #2.5 clk = ~clk;
  spi_port_setup dut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sckIn(sckIn),
    .sckOut(sckOut), .sckOutEnN(sckOutEnN), .selectOut(selectOut),
    .selectOutEnN(selectOutEnN), .shiftTick(shiftTick),
    .receiverEnable(receiverEnable));
  spi_peer peer (.clk(clk), .sck(sckOut), .sckEnN(sckOutEnN),
    .sckIn(sckIn), .edges(edges));
  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Keeps psel high so calls run back to back; wt releases it
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    erv = {31'h0, pslverr};
    penable <= 1'b0;
  endtask
  task automatic wt(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  task automatic tick(input int e);
    int n;
    int e0;
    n = 0;
    do @(posedge clk); while (shiftTick !== 1'b1);
    e0 = edges;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (shiftTick !== 1'b1);
    chk(32'(n), 32'(e));
    chk(32'(edges - e0), 32'h1);
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    wt(2);
    foreach (regs[i]) rd(regs[i], 32'h0);
    apb(1'b1, 8'h40, 32'h1);
    chk(erv, 32'h1);
    rd(8'h40, 32'h0);
    apb(1'b1, 8'h00, 32'h0c);
    apb(1'b1, 8'h04, 32'h2001);
    apb(1'b1, 8'h0c, 32'h05);
    apb(1'b1, 8'h24, 32'h5a);
    rd(8'h0c, 32'h05);
    apb(1'b1, 8'h00, 32'h0e);
    wt(5);
    chk(sckOutEnN, 1'b0);
    chk(selectOutEnN, 1'b0);
    tick(12);
    apb(1'b1, 8'h0c, 32'h01);
    apb(1'b1, 8'h04, 32'h20000);
    apb(1'b1, 8'h24, 32'h0);
    wt(5);
    rd(8'h0c, 32'h05);
    rd(8'h04, 32'h22001);
    rd(8'h24, 32'h5a);
    chk(receiverEnable, 1'b1);
    apb(1'b1, 8'h00, 32'h0c);
    apb(1'b1, 8'h0c, 32'h02);
    wt(6);
    rd(8'h0c, 32'h02);
    chk(sckOutEnN, 1'b1);
    apb(1'b1, 8'h30, 32'h1);
    apb(1'b1, 8'h00, 32'h0a);
    wt(5);
    chk(sckOutEnN, 1'b1);
    apb(1'b1, 8'h00, 32'h1);
    wt(3);
    rd(8'h0c, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h30, 32'h1);
    chk(receiverEnable, 1'b0);
    apb(1'b1, 8'h00, 32'h0e);
    wt(5);
    chk(selectOutEnN, 1'b1);
    tick(2);
    end_of_test();
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
endmodule
`default_nettype wire
